// ===== src/pss_pkg.sv
// Shared constants and helpers for the profiling state save block
package pss_pkg;

    // ************************************************************
    // Save area geometry
    // ************************************************************
    localparam int AREA_SIZE = 128;
    localparam int AREA_OFFSET = 832;
    localparam int FEATURE_BIT = 62;
    localparam int IMG_WORDS = 32;
    localparam int MEM_WORDS = 16;
    localparam int EVENT_COUNT = 6;

    // ************************************************************
    // Register byte offsets, equal to image byte offsets except status at 0x80, which lies past the image
    // ************************************************************
    localparam logic [7:0] OFS_CB_LO = 8'h00;
    localparam logic [7:0] OFS_CB_HI = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_HEAD = 8'h0C;
    localparam logic [7:0] OFS_BASE_LO = 8'h10;
    localparam logic [7:0] OFS_BASE_HI = 8'h14;
    localparam logic [7:0] OFS_SIZE = 8'h18;
    localparam logic [7:0] OFS_FILTER = 8'h1C;
    localparam logic [7:0] OFS_RECORD = 8'h20;
    localparam logic [7:0] OFS_COUNT1 = 8'h40;
    localparam logic [7:0] OFS_COUNT_LAST = 8'h54;
    localparam logic [7:0] OFS_RSVD = 8'h58;
    localparam logic [7:0] OFS_STATUS = 8'h80;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam logic [31:0] FLAGS_MASK = 32'h0000007E;
    localparam int FLAG_EVENT1_POS = 1;
    localparam logic [31:0] SIZE_MASK = 32'h0FFFFFFF;
    localparam logic [31:0] FULL_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam int EVENT_ID_POS = 0;
    localparam int EVENT_ID_W = 8;
    localparam int STATUS_BUSY_POS = 0;
    localparam int STATUS_HDR_POS = 1;

    // Writable bits of one 32-bit image word
    function automatic logic [31:0] pss_word_mask(input logic [4:0] idx);
        logic [7:0] ofs;
        ofs = {1'b0, idx, 2'b00};
        if (ofs == OFS_FLAGS)
            return FLAGS_MASK;
        else if (ofs == OFS_SIZE)
            return SIZE_MASK;
        else if (ofs >= OFS_RSVD)
            return ZERO_WORD;
        else
            return FULL_MASK;
    endfunction

endpackage

// ===== src/pss_save_word.sv
// Picks one 64-bit save word out of the flattened image
`timescale 1ns/10ps
module pss_save_word
    import pss_pkg::*;
#(
    parameter int WORDS = MEM_WORDS
)
(
    input wire logic [WORDS*64-1:0] image_flat_i,
    input wire logic [$clog2(WORDS)-1:0] index_i,
    output logic [63:0] word_o
);

    // Fewer than two words leaves the index with no bits
    if (WORDS < 2)
    begin : g_bad_words
        $error("pss_save_word needs at least two words");
    end

    // Lower address word lands in the low half
    always_comb
    begin
        word_o = image_flat_i[index_i*64 +: 64];
    end

endmodule

// ===== src/pss_save_area.sv
// Profiling state save area: internal state image, save sequencer, default restore
//
// Function
// - Bit 62 of feature control gates save
// - Component is 128 bytes at 832
// - Bytes 7-0 hold control block address
// - Flag bit 1 marks event 1 active
// - Bits 6:2 flag events 2-6; rest reserved
// - Head offset at 15-12, base 23-16
// - Size in bits 27:0, top reserved
// - Filters held in bytes 31-28
// - Pending record 63-32, zero id none
// - Event counters in bytes 87-64
// - Bytes 127-88 reserved, no state
// - Zero pointer: no write, header bit clear
// - Enabled: copy unchanged, header bit set
// - Missing component on restore clears pointer
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module pss_save_area
    import pss_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [63:0] feature_enable_control_i,
    input wire logic [63:0] request_mask_i,
    input wire logic [63:0] area_base_i,
    input wire logic save_req_i,
    input wire logic restore_req_i,
    input wire logic restore_hdr_bit_i,
    input wire logic restore_load_i,
    input wire logic [3:0] restore_index_i,
    input wire logic [63:0] restore_data_i,
    output logic mem_wr_valid_o,
    input wire logic mem_wr_ready_i,
    output logic [63:0] mem_wr_addr_o,
    output logic [63:0] mem_wr_data_o,
    output logic hdr_upd_o,
    output logic hdr_bit_o,
    output logic save_done_o,
    output logic busy_o,
    output logic [15:0] area_size_o,
    output logic [15:0] area_offset_o,
    output logic profiling_enabled_o,
    output logic [EVENT_COUNT-1:0] event_active_o,
    output logic record_pending_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Picker packs two image words into each save word
    if (IMG_WORDS != 2 * MEM_WORDS)
    begin : g_bad_words
        $error("image and save word counts disagree");
    end
    // Image must cover the whole component, no more
    if (AREA_SIZE != 4 * IMG_WORDS)
    begin : g_bad_size
        $error("component size and image size disagree");
    end

    // ************************************************************
    // State machine and storage
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_HDR = 4'b0100,
        ST_DONE = 4'b1000
    } pss_state_t;

    pss_state_t state;
    logic [31:0] image [0:IMG_WORDS-1];
    logic [MEM_WORDS*64-1:0] image_flat;
    logic [3:0] word_idx;
    logic [3:0] next_word_idx;
    logic [63:0] pick_word;
    logic [63:0] save_base;
    logic hdr_val;
    logic last_hdr;
    logic save_allowed;
    logic restore_default;
    logic cb_zero;
    logic accepted;

    assign save_allowed = feature_enable_control_i[FEATURE_BIT] & request_mask_i[FEATURE_BIT];
    assign restore_default = restore_req_i & save_allowed & ~restore_hdr_bit_i;
    assign cb_zero = (image[OFS_CB_LO[6:2]] == ZERO_WORD) && (image[OFS_CB_HI[6:2]] == ZERO_WORD);
    assign accepted = mem_wr_valid_o & mem_wr_ready_i;

    always_comb
    begin
        for (int i = 0; i < IMG_WORDS; i++)
            image_flat[i*32 +: 32] = image[i];
    end

    pss_save_word #(
        .WORDS(MEM_WORDS)
    ) u_pick (
        .image_flat_i(image_flat),
        .index_i(next_word_idx),
        .word_o(pick_word)
    );

    always_comb
    begin
        next_word_idx = word_idx;
        if (state == ST_WRITE && accepted)
            next_word_idx = word_idx + 4'h1;
    end

    // ************************************************************
    // Image storage
    // ************************************************************
    // Default restore wins over software and loads in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (reset_i || restore_default)
        begin
            for (int i = 0; i < IMG_WORDS; i++)
                image[i] <= ZERO_WORD;
        end
        else if (restore_load_i && save_allowed)
        begin
            image[{restore_index_i, 1'b0}] <= restore_data_i[31:0] & pss_word_mask({restore_index_i, 1'b0});
            image[{restore_index_i, 1'b1}] <= restore_data_i[63:32] & pss_word_mask({restore_index_i, 1'b1});
        end
        else if (reg_write_i && reg_addr_i < OFS_STATUS)
        begin
            image[reg_addr_i[6:2]] <= reg_wdata_i & pss_word_mask(reg_addr_i[6:2]);
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            reg_rdata_o <= ZERO_WORD;
        else if (reg_read_i)
        begin
            if (reg_addr_i < OFS_STATUS)
                reg_rdata_o <= image[reg_addr_i[6:2]];
            else if (reg_addr_i == OFS_STATUS)
            begin
                reg_rdata_o <= ZERO_WORD;
                reg_rdata_o[STATUS_BUSY_POS] <= (state != ST_IDLE);
                reg_rdata_o[STATUS_HDR_POS] <= last_hdr;
            end
            else
                reg_rdata_o <= ZERO_WORD;
        end
        else
            reg_rdata_o <= ZERO_WORD;
    end

    // ************************************************************
    // Save sequencer
    // ************************************************************
    // Register writes during a save land in later words; software should wait for idle
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            word_idx <= 4'h0;
            hdr_val <= 1'b0;
            save_base <= 64'h0000000000000000;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    word_idx <= 4'h0;
                    if (save_req_i)
                    begin
                        save_base <= area_base_i;
                        if (!save_allowed)
                            state <= ST_DONE;
                        else if (cb_zero)
                        begin
                            hdr_val <= 1'b0;
                            state <= ST_HDR;
                        end
                        else
                        begin
                            hdr_val <= 1'b1;
                            state <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE:
                begin
                    if (accepted)
                    begin
                        word_idx <= next_word_idx;
                        if (word_idx == 4'(MEM_WORDS - 1))
                            state <= ST_HDR;
                    end
                end
                ST_HDR:
                    state <= ST_IDLE;
                ST_DONE:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Memory write port
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            mem_wr_valid_o <= 1'b0;
            mem_wr_addr_o <= 64'h0000000000000000;
            mem_wr_data_o <= 64'h0000000000000000;
        end
        else if (state == ST_WRITE)
        begin
            if (!mem_wr_valid_o || accepted)
            begin
                if (accepted && word_idx == 4'(MEM_WORDS - 1))
                    mem_wr_valid_o <= 1'b0;
                else
                begin
                    mem_wr_valid_o <= 1'b1;
                    mem_wr_addr_o <= save_base + 64'(AREA_OFFSET) + {57'h0, next_word_idx, 3'b000};
                    mem_wr_data_o <= pick_word;
                end
            end
        end
        else
            mem_wr_valid_o <= 1'b0;
    end

    // ************************************************************
    // Header update and status
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            hdr_upd_o <= 1'b0;
            hdr_bit_o <= 1'b0;
            save_done_o <= 1'b0;
            last_hdr <= 1'b0;
        end
        else
        begin
            hdr_upd_o <= (state == ST_HDR);
            save_done_o <= (state == ST_HDR) || (state == ST_DONE);
            if (state == ST_HDR)
            begin
                hdr_bit_o <= hdr_val;
                last_hdr <= hdr_val;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            busy_o <= 1'b0;
            area_size_o <= 16'h0000;
            area_offset_o <= 16'h0000;
            profiling_enabled_o <= 1'b0;
            event_active_o <= '0;
            record_pending_o <= 1'b0;
        end
        else
        begin
            busy_o <= (state != ST_IDLE) || save_req_i;
            area_size_o <= 16'(AREA_SIZE);
            area_offset_o <= 16'(AREA_OFFSET);
            profiling_enabled_o <= ~cb_zero;
            event_active_o <= image[OFS_FLAGS[6:2]][FLAG_EVENT1_POS +: EVENT_COUNT];
            record_pending_o <= (image[OFS_RECORD[6:2]][EVENT_ID_POS +: EVENT_ID_W] != 8'h00);
        end
    end

endmodule

// ===== dv/pss_save_area_properties.sv
// Port checks for the profiling state save block
`timescale 1ns/10ps
module pss_save_area_checker
    import pss_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [63:0] feature_enable_control_i,
    input wire logic [63:0] request_mask_i,
    input wire logic [63:0] area_base_i,
    input wire logic save_req_i,
    input wire logic restore_req_i,
    input wire logic restore_hdr_bit_i,
    input wire logic mem_wr_valid_o,
    input wire logic mem_wr_ready_i,
    input wire logic [63:0] mem_wr_addr_o,
    input wire logic [63:0] mem_wr_data_o,
    input wire logic hdr_upd_o,
    input wire logic hdr_bit_o,
    input wire logic save_done_o,
    input wire logic busy_o,
    input wire logic [15:0] area_size_o,
    input wire logic [15:0] area_offset_o,
    input wire logic profiling_enabled_o,
    input wire logic [EVENT_COUNT-1:0] event_active_o,
    input wire logic record_pending_o
);
    wire logic gate = feature_enable_control_i[FEATURE_BIT] & request_mask_i[FEATURE_BIT];
    wire logic start = save_req_i & ~busy_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    chk_area_geometry:
    assert property (!$past(reset_i) |-> area_size_o == 16'h0080 && area_offset_o == 16'h0340)
        else $error("area size or offset wrong");
    chk_flag_reserved:
    assert property ($past(reg_read_i) && $past(reg_addr_i) == 8'h08 |-> !reg_rdata_o[0] && reg_rdata_o[31:7] == 25'h0)
        else $error("reserved flag bits not zero");
    chk_size_reserved:
    assert property ($past(reg_read_i) && $past(reg_addr_i) == 8'h18 |-> reg_rdata_o[31:28] == 4'h0)
        else $error("ring size top bits not zero");
    chk_tail_reserved:
    assert property ($past(reg_read_i) && $past(reg_addr_i) inside {[8'h58:8'h7F]} |-> reg_rdata_o == 32'h0)
        else $error("reserved tail holds state");
    chk_gated_save:
    assert property (start && !gate |=> !mem_wr_valid_o ##1 save_done_o && !hdr_upd_o && !mem_wr_valid_o)
        else $error("gated save misbehaved");
    chk_null_save:
    assert property (start && gate && !profiling_enabled_o |=> !mem_wr_valid_o ##1 hdr_upd_o && !hdr_bit_o && save_done_o)
        else $error("null save misbehaved");
    chk_first_word:
    assert property (start && gate && profiling_enabled_o |-> ##2 mem_wr_valid_o && mem_wr_addr_o == area_base_i + 64'h340)
        else $error("first save word address wrong");
    chk_write_hold:
    assert property (mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o))
        else $error("write dropped while stalled");
    chk_default_restore:
    assert property (restore_req_i && gate && !restore_hdr_bit_i |-> ##2 !profiling_enabled_o && event_active_o == 6'h0)
        else $error("default restore left state");
    chk_done_with_hdr:
    assert property (hdr_upd_o |-> save_done_o && !mem_wr_valid_o)
        else $error("header update without done");
endmodule
bind pss_save_area pss_save_area_checker chk (.*);

// ===== dv/pss_mem_model.sv
// Save area memory, stalls every other cycle in slow mode
`timescale 1ns/10ps
module pss_mem_model
(
    input wire logic clock_i,
    input wire logic slow_i,
    input wire logic wr_valid_i,
    input wire logic [63:0] wr_addr_i,
    input wire logic [63:0] wr_data_i,
    output logic wr_ready_o
);
    // Fixed store; bases used by the bench never alias
    logic [63:0] mem [0:4095];
    int writes = 0;
    logic phase = 1'h0;
    assign wr_ready_o = ~slow_i | phase;
    always @(posedge clock_i)
    begin
        phase <= ~phase;
        if (wr_valid_i && wr_ready_o)
        begin
            mem[wr_addr_i[14:3]] <= wr_data_i;
            writes <= writes + 1;
        end
    end
    function automatic logic [63:0] peek(input logic [63:0] a);
        return mem[a[14:3]];
    endfunction
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the profiling state save block
`timescale 1ns/10ps
module testbench;
    import pss_pkg::*;
    logic clock_i = 1'h0, reset_i = 1'h1, slow = 1'h0, hb, hu;
    logic reg_write_i = 1'h0, reg_read_i = 1'h0, save_req_i = 1'h0;
    logic restore_req_i = 1'h0, restore_hdr_bit_i = 1'h0, restore_load_i = 1'h0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
    logic [3:0] restore_index_i = 4'h0;
    logic [63:0] feature_enable_control_i = 64'h0, request_mask_i = 64'h0;
    logic [63:0] area_base_i = 64'h0, restore_data_i = 64'h0, mem_wr_addr_o, mem_wr_data_o;
    logic mem_wr_valid_o, mem_wr_ready_i, hdr_upd_o, hdr_bit_o, save_done_o, busy_o;
    logic profiling_enabled_o, record_pending_o;
    logic [15:0] area_size_o, area_offset_o;
    logic [EVENT_COUNT-1:0] event_active_o;
    int miscompares = 0, comparisons = 0, cycles = 0;
    pss_save_area uut (.*);
    pss_mem_model far (.clock_i(clock_i), .slow_i(slow), .wr_valid_i(mem_wr_valid_o),
        .wr_addr_i(mem_wr_addr_o), .wr_data_i(mem_wr_data_o), .wr_ready_o(mem_wr_ready_i));
    initial forever #2.5 clock_i = ~clock_i;
    // Ceiling well above the few hundred cycles needed
    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            miscompares++;
            complete_run();
        end
    end
    function automatic logic [31:0] pat(int k);
        return {8'(k + 1), 8'(k), 16'hB2A1};
    endfunction
    function automatic logic [31:0] msk(int k);
        return k == 2 ? 32'h7E : k == 6 ? 32'h0FFFFFFF : k >= 22 ? 32'h0 : 32'hFFFFFFFF;
    endfunction
    task check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'h1;
        @(posedge clock_i);
        reg_write_i <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'h1;
        @(posedge clock_i);
        reg_read_i <= 1'h0;
        #1;
        d = reg_rdata_o;
    endtask
    task save(input logic [63:0] b);
        int n;
        @(posedge clock_i);
        area_base_i <= b;
        save_req_i <= 1'h1;
        @(posedge clock_i);
        save_req_i <= 1'h0;
        #1;
        for (n = 0; n < 100 && save_done_o !== 1'h1; n++)
        begin
            @(posedge clock_i);
            #1;
        end
        hb = hdr_bit_o;
        hu = hdr_upd_o;
    endtask
    task restore(input logic h);
        @(posedge clock_i);
        restore_req_i <= 1'h1;
        restore_hdr_bit_i <= h;
        @(posedge clock_i);
        restore_req_i <= 1'h0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task load(input logic [3:0] i, input logic [63:0] v);
        @(posedge clock_i);
        restore_load_i <= 1'h1;
        restore_index_i <= i;
        restore_data_i <= v;
        @(posedge clock_i);
        restore_load_i <= 1'h0;
    endtask
    task t_regs;
        for (int k = 0; k < 33; k++)
            wr(8'(k * 4), pat(k));
        for (int k = 0; k < 32; k++)
        begin
            rd(8'(k * 4));
            check(d, pat(k) & msk(k));
        end
        check(area_size_o, 64'd128);
        check(area_offset_o, 64'd832);
        check(event_active_o, 6'((pat(2) & 32'h7E) >> 1));
        check(record_pending_o, 1'h1);
        $display("test regs done");
    endtask
    task t_save;
        @(posedge clock_i);
        request_mask_i <= 64'h4000000000000000;
        save(64'h1000);
        check(far.writes, 0);
        check(hu, 1'h0);
        @(posedge clock_i);
        feature_enable_control_i <= 64'h4000000000000000;
        slow <= 1'h1;
        save(64'h2000);
        check(far.writes, 16);
        check({hu, hb}, 2'h3);
        for (int i = 0; i < 16; i++)
            check(far.peek(64'h2340 + 8 * i), {pat(2 * i + 1) & msk(2 * i + 1), pat(2 * i) & msk(2 * i)});
        rd(8'h80);
        check(d, 32'h2);
        $display("test save done");
    endtask
    task t_restore;
        restore(1'h1);
        check(profiling_enabled_o, 1'h1);
        restore(1'h0);
        check({profiling_enabled_o, record_pending_o, event_active_o}, 8'h0);
        rd(8'h00);
        check(d, 32'h0);
        save(64'h3000);
        check({hu, hb}, 2'h2);
        check(far.writes, 16);
        // Control block pointer loaded nonzero, head as zero, flags overfilled to test the mask
        load(4'h0, 64'h0000000100001000);
        load(4'h1, 64'h00000000FFFFFFFF);
        rd(8'h04);
        check(d, 32'h1);
        check(event_active_o, 6'h3F);
        @(posedge clock_i);
        slow <= 1'h0;
        save(64'h4000);
        check({hu, hb}, 2'h3);
        check(far.peek(64'h4340), 64'h0000000100001000);
        check(far.peek(64'h4348), 64'h7E);
        $display("test restore done");
    endtask
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'h0;
        t_regs();
        t_save();
        t_restore();
        complete_run();
    end
endmodule
